/* File: shared/lid_pkg.sv */
// Shared constants and types for the LCD instruction decoder link
package lid_pkg;
  // ==========================================================
  // Widths and sizes
  localparam int unsigned PTR_W = 7;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned TEXT_DEPTH = 64;
  // Text rows start at this pointer value, 16 words each
  localparam logic [6:0] TEXT_BASE = 7'h00;
  localparam logic [6:0] TEXT_LAST = 7'h3F;
  localparam logic [6:0] GLYPH_MASK = 7'h3F;
  localparam logic [6:0] SCROLL_MASK = 7'h3F;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  // ==========================================================
  // Reset values
  localparam logic [6:0] PTR_RST = 7'h00;
  localparam logic ENTRY_INC_RST = 1'b1;
  localparam logic WIDTH8_RST = 1'b1;
  // ==========================================================
  // Timing: instruction execution at 100 MHz
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned EXEC_NS = 72000;
  localparam int unsigned EXEC_CYC = EXEC_NS / CLK_NS;
  localparam int unsigned BUSY_W = 13;
  // ==========================================================
  // Target of a data access
  typedef enum logic [1:0] {
    LID_TGT_TEXT,
    LID_TGT_GLYPH,
    LID_TGT_GRAPHIC
  } lid_tgt_e;
endpackage

/* File: shared/lid_if.sv */
// Host to controller parallel instruction link
`timescale 1ns/10ps
interface lid_if;
  // Register or RAM select: 1 for RAM data
  logic reg_or_ram_select;
  // Read not write
  logic rd_not_wr;
  // One-cycle access strobe
  logic strobe;
  // Byte written by the host
  logic [7:0] wdata;
  // Byte returned by the controller, valid cycle after a read strobe
  logic [7:0] rdata;
  // Busy indicator, level
  logic busy_indicator;
  modport device (input reg_or_ram_select, input rd_not_wr, input strobe, input wdata,
                  output rdata, output busy_indicator);
  modport host (output reg_or_ram_select, output rd_not_wr, output strobe, output wdata,
                input rdata, input busy_indicator);
endinterface

/* File: rtl/lid_busy_timer.sv */
// Busy timer counting one instruction execution time
`timescale 1ns/10ps
module lid_busy_timer (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  output logic busy_o
);
  // ==========================================================
  // Down counter
  logic [lid_pkg::BUSY_W-1:0] cnt_q;
  // Reload on start, else count down to zero
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else if (start_i) begin
      cnt_q <= lid_pkg::BUSY_W'(lid_pkg::EXEC_CYC);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  // Busy while counting
  assign busy_o = (cnt_q != '0);
endmodule

/* File: rtl/lid_device.sv */
// Controller end: instruction decoder with settings, pointer and text RAM
// Function
// - Clear fills text RAM, pointer zero
// - Clear forces entry increment
// - Home zeroes pointer, RAM untouched
// - Data access steps pointer per direction
// - Shift bit shifts display per direction
// - Display, cursor, blink flags set independently
// - Blink enables cursor character blink
// - Cursor move steps pointer, display shift not
// - Width bit selects 8 or 4 bit; only stored in bus_width_select_o, the link always takes whole bytes
// - Host changes width before set select
// - Glyph address loads six bits
// - Text address loads pointer, four rows
// - Status gives busy and pointer; busy refuses
// - Two bytes per word, step after second
// - First read after address is dummy
// - Extended clear code enters standby
// - Scroll select chooses scroll or glyph
// - Reverse toggles selected row
// - Row field picks row one to four
// - Graphic bit turns graphic on/off
// - Host changes width/graphic before set select
// - Scroll address loads six bits
// - Set select persists until changed
`timescale 1ns/10ps
module lid_device (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  lid_if.device link,
  output logic display_on_o,
  output logic cursor_on_o,
  output logic blink_on_o,
  output logic entry_inc_o,
  output logic entry_shift_o,
  output logic bus_width_select_o,
  output logic extended_set_select_o,
  output logic scroll_addr_select_o,
  output logic graphic_on_o,
  output logic standby_o,
  output logic [3:0] reverse_rows_o,
  output logic [5:0] scroll_o,
  output logic [5:0] shift_pos_o,
  output logic [6:0] ram_pointer_o,
  output logic [1:0] target_o
);
  // ==========================================================
  // Storage and state
  logic [15:0] text_ram [lid_pkg::TEXT_DEPTH];   // Text RAM words
  logic [6:0] ptr_q;                            // Ram pointer
  logic hi_done_q;                              // First byte of pair taken
  logic [7:0] hi_byte_q;                        // Held first byte
  logic dummy_q;                                // Next read is dummy
  logic rd_half_q;                              // Next read byte is low half
  logic [7:0] rdata_q;                          // Read return
  logic [15:0] rd_word_q;                       // Prefetched word
  lid_pkg::lid_tgt_e tgt_q;                     // Data target
  logic clr_act_q;                              // Clear sweep running
  logic [5:0] clr_idx_q;                        // Clear sweep index
  logic busy;                                   // Timer busy
  logic take;                                   // Accepted access
  logic cmd_wr;
  logic dat_wr;
  logic dat_rd;
  logic st_rd;
  logic [7:0] b;
  logic step_dir;
  // ==========================================================
  // Access qualification
  // busy refuses writes
  assign take = link.strobe && !(busy || clr_act_q);
  assign b = link.wdata;
  assign cmd_wr = take && !link.reg_or_ram_select && !link.rd_not_wr;
  assign dat_wr = take && link.reg_or_ram_select && !link.rd_not_wr;
  assign dat_rd = take && link.reg_or_ram_select && link.rd_not_wr;
  // Status reads are always allowed so the host can poll
  assign st_rd = link.strobe && !link.reg_or_ram_select && link.rd_not_wr;
  lid_busy_timer u_busy (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(cmd_wr || dat_wr || dat_rd),
    .busy_o(busy)
  );
  // busy combines timer and clear sweep
  assign link.busy_indicator = busy || clr_act_q;
  // ==========================================================
  // Instruction decode, settings
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      display_on_o <= 1'b0;
      cursor_on_o <= 1'b0;
      blink_on_o <= 1'b0;
      entry_inc_o <= lid_pkg::ENTRY_INC_RST;
      entry_shift_o <= 1'b0;
      bus_width_select_o <= lid_pkg::WIDTH8_RST;
      extended_set_select_o <= 1'b0;
      scroll_addr_select_o <= 1'b0;
      graphic_on_o <= 1'b0;
      standby_o <= 1'b0;
      reverse_rows_o <= '0;
      scroll_o <= '0;
    end else if (cmd_wr) begin
      standby_o <= 1'b0;
      if (b[7]) begin
        // Address load, handled by pointer process
      end else if (b[6]) begin
        if (extended_set_select_o && scroll_addr_select_o) scroll_o <= b[5:0];
      end else if (b[5]) begin
        bus_width_select_o <= b[4];
        extended_set_select_o <= b[2];
        // graphic bit in extended set only
        if (extended_set_select_o && b[2]) graphic_on_o <= b[1];
      end else if (!extended_set_select_o) begin
        if (b[3]) begin
          display_on_o <= b[2];
          cursor_on_o <= b[1];
          blink_on_o <= b[0];
        end else if (b[2]) begin
          // Entry mode
          entry_inc_o <= b[1];
          entry_shift_o <= b[0];
        end else if (!b[1] && b[0]) begin
          entry_inc_o <= 1'b1;
        end
      end else begin
        if (b[2]) begin
          reverse_rows_o[b[1:0]] <= !reverse_rows_o[b[1:0]];
        end else if (b[1]) begin
          scroll_addr_select_o <= b[0];
        end else if (b[0]) begin
          standby_o <= 1'b1;
        end
      end
    end
  end
  // ==========================================================
  // Pointer, display shift, pairing
  assign step_dir = entry_inc_o;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ptr_q <= lid_pkg::PTR_RST;
      shift_pos_o <= '0;
      hi_done_q <= 1'b0;
      hi_byte_q <= '0;
      tgt_q <= lid_pkg::LID_TGT_TEXT;
    end else if (cmd_wr) begin
      hi_done_q <= 1'b0;
      if (b[7]) begin
        ptr_q <= {1'b0, b[5:0]};
        tgt_q <= (extended_set_select_o) ? lid_pkg::LID_TGT_GRAPHIC : lid_pkg::LID_TGT_TEXT;
      end else if (b[6]) begin
        if (!(extended_set_select_o && scroll_addr_select_o)) begin
          ptr_q <= b[6:0] & lid_pkg::GLYPH_MASK;
          tgt_q <= lid_pkg::LID_TGT_GLYPH;
        end
      end else if (!b[5] && !extended_set_select_o) begin
        if (b[4]) begin
          if (!b[3]) ptr_q <= b[2] ? ptr_q + 7'h01 : ptr_q - 7'h01;
          else shift_pos_o <= b[2] ? shift_pos_o + 6'h01 : shift_pos_o - 6'h01;
        end else if (b[3] || b[2]) begin
          // Flag instructions leave pointer
        end else if (b[1] || b[0]) begin
          ptr_q <= lid_pkg::PTR_RST;
          tgt_q <= lid_pkg::LID_TGT_TEXT;
          if (b[1]) shift_pos_o <= '0;
        end
      end
    end else if (dat_wr) begin
      hi_done_q <= !hi_done_q;
      hi_byte_q <= b;
      if (hi_done_q) begin
        ptr_q <= step_dir ? ptr_q + 7'h01 : ptr_q - 7'h01;
        if (entry_shift_o) shift_pos_o <= step_dir ? shift_pos_o + 6'h01 : shift_pos_o - 6'h01;
      end
    end else if (dat_rd && !dummy_q && rd_half_q) begin
      ptr_q <= step_dir ? ptr_q + 7'h01 : ptr_q - 7'h01;
      if (entry_shift_o) shift_pos_o <= step_dir ? shift_pos_o + 6'h01 : shift_pos_o - 6'h01;
    end
  end
  // ==========================================================
  // Text RAM writes and clear sweep
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      clr_act_q <= 1'b0;
      clr_idx_q <= '0;
    end else if (clr_act_q) begin
      // space fill, one word per cycle
      text_ram[clr_idx_q] <= {lid_pkg::SPACE_CODE, lid_pkg::SPACE_CODE};
      clr_idx_q <= clr_idx_q + 6'h01;
      if (clr_idx_q == lid_pkg::TEXT_LAST[5:0]) clr_act_q <= 1'b0;
    end else if (cmd_wr && !extended_set_select_o && b[7:0] == 8'h01) begin
      clr_act_q <= 1'b1;
      clr_idx_q <= '0;
    end else if (dat_wr && hi_done_q && tgt_q == lid_pkg::LID_TGT_TEXT) begin
      text_ram[ptr_q[5:0]] <= {hi_byte_q, b};
    end
  end
  // ==========================================================
  // Read path, dummy read handling
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dummy_q <= 1'b1;
      rd_half_q <= 1'b0;
      rdata_q <= '0;
      rd_word_q <= '0;
    end else begin
      if (cmd_wr || dat_wr) begin
        // new address or write rearms dummy
        dummy_q <= 1'b1;
        rd_half_q <= 1'b0;
      end else if (dat_rd) begin
        if (dummy_q) begin
          // dummy returns stale latch, fetches word
          dummy_q <= 1'b0;
          rd_word_q <= text_ram[ptr_q[5:0]];
          rdata_q <= rd_word_q[7:0];
        end else if (!rd_half_q) begin
          rdata_q <= rd_word_q[15:8];
          rd_half_q <= 1'b1;
        end else begin
          rdata_q <= rd_word_q[7:0];
          rd_half_q <= 1'b0;
          rd_word_q <= text_ram[step_dir ? ptr_q[5:0] + 6'h01 : ptr_q[5:0] - 6'h01];
        end
      end else if (st_rd) begin
        rdata_q <= {busy || clr_act_q, ptr_q};
      end
    end
  end
  assign link.rdata = rdata_q;
  assign ram_pointer_o = ptr_q;
  assign target_o = tgt_q;
endmodule

/* File: rtl/lid_host.sv */
// Host end: issues one instruction or data byte per user request
`timescale 1ns/10ps
module lid_host (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  lid_if.host link,
  input wire logic req_i,
  input wire logic req_ram_i,
  input wire logic req_read_i,
  input wire logic [7:0] req_data_i,
  output logic ready_o,
  output logic done_o,
  output logic [7:0] resp_data_o
);
  // ==========================================================
  // Sequencer: poll busy, then issue
  typedef enum logic [1:0] {LID_H_IDLE, LID_H_ISSUE, LID_H_WAIT} lid_hst_e;
  lid_hst_e st_q;
  logic ram_q;
  logic rd_q;
  logic [7:0] dat_q;
  logic stat_rd;                                // Pending access is a status read
  // Host waits for busy low before every access except a status read
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_q <= LID_H_IDLE;
      ram_q <= 1'b0;
      rd_q <= 1'b0;
      dat_q <= '0;
      done_o <= 1'b0;
      resp_data_o <= '0;
    end else begin
      done_o <= 1'b0;
      unique case (st_q)
        LID_H_IDLE: begin
          if (req_i) begin
            ram_q <= req_ram_i;
            rd_q <= req_read_i;
            dat_q <= req_data_i;
            st_q <= LID_H_ISSUE;
          end
        end
        LID_H_ISSUE: begin
          // status reads go out while busy
          if (!link.busy_indicator || stat_rd) st_q <= LID_H_WAIT;
        end
        LID_H_WAIT: begin
          resp_data_o <= link.rdata;
          done_o <= 1'b1;
          st_q <= LID_H_IDLE;
        end
      endcase
    end
  end
  // Link drive; the caller orders width before set select changes
  // Status reads are how busy is watched, so they never wait on it
  assign stat_rd = rd_q && !ram_q;
  assign link.strobe = (st_q == LID_H_ISSUE) && (!link.busy_indicator || stat_rd);
  assign link.reg_or_ram_select = ram_q;
  assign link.rd_not_wr = rd_q;
  assign link.wdata = dat_q;
  assign ready_o = (st_q == LID_H_IDLE);
endmodule

/* File: tb/lid_link_asserts.sv */
// Checker for the host to controller instruction link
`timescale 1ns/10ps
module lid_link_asserts (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic reg_or_ram_select,
  input wire logic rd_not_wr,
  input wire logic strobe,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic busy_indicator
);
  // ==========================================================
  // Busy length counter
  // Cycles busy has been high so far; the clear sweep overlaps the timer
  logic [13:0] busy_cnt_q;
  // One execution period in clock cycles
  localparam int unsigned BUSY_LEN = lid_pkg::EXEC_CYC;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !busy_indicator) begin
      busy_cnt_q <= 14'h0000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 14'h0001;
    end
  end
  // ==========================================================
  // Sequences and properties
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Status read: instruction register read, never refused
  sequence s_status;
    strobe && rd_not_wr && !reg_or_ram_select;
  endsequence
  // Any access that starts an execution
  sequence s_taken;
    strobe && !busy_indicator && !(rd_not_wr && !reg_or_ram_select);
  endsequence
  // Clear code taken while idle
  sequence s_clear;
    s_taken ##0 (!reg_or_ram_select && !rd_not_wr && wdata == 8'h01);
  endsequence
  a_busy_after_take: assert property (s_taken |=> busy_indicator)
    else $error("busy did not follow a taken access");
  a_clear_busy_run: assert property (s_clear |=> busy_indicator [*8])
    else $error("busy dropped early after clear");
  a_status_busy_bit: assert property (s_status ##0 busy_indicator |=> rdata[7])
    else $error("status read missed busy bit");
  a_status_idle_bit: assert property (s_status ##0 !busy_indicator |=> !rdata[7])
    else $error("status read showed busy while idle");
  a_status_no_busy: assert property (s_status ##0 !busy_indicator |=> !busy_indicator)
    else $error("status read started an execution");
  a_host_polls_busy: assert property (strobe && busy_indicator |-> rd_not_wr && !reg_or_ram_select)
    else $error("host strobed a write while busy");
  a_strobe_single: assert property (strobe |=> !strobe)
    else $error("strobe longer than one cycle");
  a_rdata_holds: assert property (!(strobe && rd_not_wr) |=> $stable(rdata))
    else $error("read data changed without a read");
  a_busy_min_len: assert property ($fell(busy_indicator) |-> busy_cnt_q >= BUSY_LEN)
    else $error("busy period too short");
  a_busy_max_len: assert property (busy_cnt_q <= BUSY_LEN)
    else $error("busy period too long");
endmodule

/* File: tb/tb_lcd_instruction_decoder.sv */
// Self-checking bench joining the host and controller ends
`timescale 1ns/10ps
module tb_lcd_instruction_decoder;
  // ==========================================================
  // Signals
  logic mclk_i;
  logic sys_rst_i;
  logic req_i;
  logic req_ram_i;
  logic req_read_i;
  logic [7:0] req_data_i;
  logic ready_o;
  logic done_o;
  logic [7:0] resp_data_o;
  logic [2:0] dcb;
  logic entry_inc_o;
  logic width_o;
  logic ext_o;
  logic standby_o;
  logic [3:0] rev_o;
  logic [6:0] ptr_o;
  logic shift_o;
  logic sr_o;
  logic gfx_o;
  logic [5:0] scr_o;
  logic [5:0] pos_o;
  logic [1:0] tgt_o;
  int num_errors;
  int n_checks;
  int cyc;
  logic [7:0] rsp;
  lid_if lnk();
  // ==========================================================
  // Both ends and the checker
  lid_host lid_host_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(lnk),
    .req_i(req_i), .req_ram_i(req_ram_i), .req_read_i(req_read_i),
    .req_data_i(req_data_i), .ready_o(ready_o), .done_o(done_o), .resp_data_o(resp_data_o));
  lid_device lid_device_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(lnk),
    .display_on_o(dcb[2]), .cursor_on_o(dcb[1]), .blink_on_o(dcb[0]),
    .entry_inc_o(entry_inc_o), .entry_shift_o(shift_o), .bus_width_select_o(width_o),
    .extended_set_select_o(ext_o), .scroll_addr_select_o(sr_o), .graphic_on_o(gfx_o),
    .standby_o(standby_o), .reverse_rows_o(rev_o), .scroll_o(scr_o), .shift_pos_o(pos_o),
    .ram_pointer_o(ptr_o), .target_o(tgt_o));
  lid_link_asserts lid_link_asserts_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .reg_or_ram_select(lnk.reg_or_ram_select), .rd_not_wr(lnk.rd_not_wr),
    .strobe(lnk.strobe), .wdata(lnk.wdata), .rdata(lnk.rdata),
    .busy_indicator(lnk.busy_indicator));
  // Clock, 10 ns period
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // ==========================================================
  // Tasks
  // Compare seen against expected
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One user request; idle_first polls busy so writes are never refused
  task automatic op(input logic ram, input logic rd, input logic [7:0] d,
                    input logic idle_first);
    int n;
    n = 0;
    while (idle_first && lnk.busy_indicator !== 1'b0 && n < 9000) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    @(posedge mclk_i);
    req_i <= 1'b1;
    req_ram_i <= ram;
    req_read_i <= rd;
    req_data_i <= d;
    @(posedge mclk_i);
    req_i <= 1'b0;
    n = 0;
    #1;
    while (done_o !== 1'b1 && n < 20) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk({7'h00, done_o}, 8'h01);
    rsp = resp_data_o;
  endtask
  // Hang guard: thirteen busy waits of one execution period fit inside
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 98000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    req_i = 1'b0;
    req_ram_i = 1'b0;
    req_read_i = 1'b0;
    req_data_i = 8'h00;
    num_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk({6'h00, width_o, entry_inc_o}, 8'h03);
    op(1'b0, 1'b1, 8'h00, 1'b1);
    chk(rsp, 8'h00);
    op(1'b0, 1'b0, 8'h0F, 1'b1);
    chk({5'h00, dcb}, 8'h07);
    // Status while busy shows busy and the loaded row 1 offset 5
    op(1'b0, 1'b0, 8'h85, 1'b1);
    chk({6'h00, tgt_o}, 8'h00);
    op(1'b0, 1'b1, 8'h00, 1'b0);
    chk(rsp, 8'h85);
    op(1'b1, 1'b0, 8'h41, 1'b1);
    chk({1'b0, ptr_o}, 8'h05);
    op(1'b1, 1'b0, 8'h42, 1'b1);
    chk({1'b0, ptr_o}, 8'h06);
    // Cursor left back onto the word; any instruction rearms the dummy read
    op(1'b0, 1'b0, 8'h10, 1'b1);
    chk({1'b0, ptr_o}, 8'h05);
    // Read back: dummy, then high and low byte
    op(1'b1, 1'b1, 8'h00, 1'b1);
    op(1'b1, 1'b1, 8'h00, 1'b1);
    chk(rsp, 8'h41);
    op(1'b1, 1'b1, 8'h00, 1'b1);
    chk(rsp, 8'h42);
    chk({1'b0, ptr_o}, 8'h06);
    // Decrement with shift, then clear forces increment back
    op(1'b0, 1'b0, 8'h05, 1'b1);
    chk({6'h00, entry_inc_o, shift_o}, 8'h01);
    op(1'b0, 1'b0, 8'h01, 1'b1);
    chk({1'b0, ptr_o}, 8'h00);
    chk({7'h00, entry_inc_o}, 8'h01);
    // Mid-run reset cuts the clear sweep and busy period short
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk({2'h0, pos_o}, 8'h00);
    chk({2'h0, scr_o}, 8'h00);
    chk({5'h00, gfx_o, sr_o, shift_o}, 8'h00);
    op(1'b0, 1'b1, 8'h00, 1'b1);
    chk(rsp, 8'h00);
    // Extended set with width and graphic kept, scroll, reverse row two, standby
    op(1'b0, 1'b0, 8'h34, 1'b1);
    chk({6'h00, width_o, ext_o}, 8'h03);
    chk({7'h00, gfx_o}, 8'h00);
    op(1'b0, 1'b0, 8'h03, 1'b1);
    chk({7'h00, sr_o}, 8'h01);
    op(1'b0, 1'b0, 8'h45, 1'b1);
    chk({2'h0, scr_o}, 8'h05);
    chk({1'b0, ptr_o}, 8'h00);
    op(1'b0, 1'b0, 8'h05, 1'b1);
    chk({4'h0, rev_o}, 8'h02);
    chk({7'h00, ext_o}, 8'h01);
    op(1'b0, 1'b0, 8'h01, 1'b1);
    chk({7'h00, standby_o}, 8'h01);
    print_verdict();
  end
endmodule
